// ===== logic/buck_setting_regs.sv
/*
  buck b and buck c setting registers behind a classic wishbone slave,
  with a commit register for buck b and monitor blanking after accepted buck b and buck c writes.
  assumes the password sequencer outside drives PASSWORD_OK_IN as a level
  in this clock domain and drops it itself once a protected write is done.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
`include "buck_regs_defines.svh"
module buck_setting_regs
  import buck_regs_pkg::*;
#(
  parameter int BLANK_CYCLES = `BLANK_CYCLES
) (
  input  wire logic                    CORE_CLK_IN,
  input  wire logic                    SYS_RST_IN,
  input  wire logic                    WB_CYC_IN,
  input  wire logic                    WB_STB_IN,
  input  wire logic                    WB_WE_IN,
  input  wire logic [31:0]             WB_ADR_IN,
  input  wire logic [3:0]              WB_SEL_IN,
  input  wire logic [31:0]             WB_DAT_IN,
  output logic      [31:0]             WB_DAT_OUT,
  output logic                         WB_ACK_OUT,
  input  wire logic                    PASSWORD_OK_IN,
  input  wire logic                    DEFAULT_SELECT_RESISTOR_IN,
  input  wire buck_regs_pkg::vcode_t   BUCK_C_ALT_CODE_IN,
  output buck_regs_pkg::vcode_t        BUCK_B_VOLTAGE_CODE_OUT,
  output logic                         BUCK_B_LIGHT_LOAD_SKIP_ENABLE_OUT,
  output buck_regs_pkg::vcode_t        BUCK_C_VOLTAGE_CODE_OUT,
  output logic                         BUCK_C_LIGHT_LOAD_SKIP_ENABLE_OUT,
  output logic                         MONITOR_BLANK_OUT
);
  reg8_t      buck_b_setting;
  reg8_t      buck_c_setting;
  vcode_t     buck_b_applied;
  bus_state_t bus_state;
  logic       default_select_resistor_meta;
  logic       default_select_resistor_sync;
  logic       strap_done;
  logic       commit_seen;
  blank_if    bif ();

  // the blanking assertions need a window of at least eight cycles
  if (BLANK_CYCLES < 8 || BLANK_CYCLES >= (1 << `BLANK_CNT_W)) begin : g_bad_blank
    $error("buck_setting_regs: BLANK_CYCLES out of range");
  end

  // synchronised default-select level, first stage read only by second;
  // no reset here so the pin level is already settled when reset ends
  always_ff @(posedge CORE_CLK_IN) begin
    default_select_resistor_meta <= DEFAULT_SELECT_RESISTOR_IN;
    default_select_resistor_sync <= default_select_resistor_meta;
  end

  // address decode, byte lane 0 carries the 8-bit registers
  wire [29:0] word_index = WB_ADR_IN[31:2];
  wire        req        = WB_CYC_IN && WB_STB_IN && (bus_state == BUS_IDLE);
  wire        hit_b      = (word_index == 30'(`BUCK_B_INDEX));
  wire        hit_c      = (word_index == 30'(`BUCK_C_INDEX));
  wire        hit_commit = (word_index == 30'(`COMMIT_INDEX));
  wire        lane0_wr   = req && WB_WE_IN && WB_SEL_IN[0];
  wire        prot_ok    = lane0_wr && PASSWORD_OK_IN;
  wire        wr_b       = prot_ok && hit_b;
  wire        wr_c       = prot_ok && hit_c;
  wire        wr_commit  = lane0_wr && hit_commit;
  wire        go         = wr_commit &&
                           (WB_DAT_IN[`COMMIT_BIT] || WB_DAT_IN[`ALT_COMMIT_BIT]);
  // bit 6 forced low on write, reserved bit never stored as one
  wire reg8_t wr_value   = {WB_DAT_IN[`SKIP_BIT], 1'b0, WB_DAT_IN[`CODE_MSB:0]};

  assign bif.start = wr_b || wr_c;

  // read mux, unmapped addresses read zero and still ack
  wire reg8_t rd_value = hit_b ? buck_b_setting :
                         hit_c ? buck_c_setting : 8'h00;

  // one wait state: ack the cycle after the request, then drop it
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      bus_state <= BUS_IDLE;
    else if (bus_state == BUS_ACK)
      bus_state <= BUS_IDLE;
    else if (WB_CYC_IN && WB_STB_IN)
      bus_state <= BUS_ACK;
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      WB_DAT_OUT <= 32'h0000_0000;
    else if (req && !WB_WE_IN)
      WB_DAT_OUT <= {24'h00_0000, rd_value};
  end

  assign WB_ACK_OUT = (bus_state == BUS_ACK);

  // buck b register, rejected writes leave it alone
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      buck_b_setting <= `BUCK_B_RESET;
    else if (wr_b)
      buck_b_setting <= wr_value;
  end

  // strap is caught on the first edge after reset ends, not in reset
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      strap_done <= 1'b0;
    else
      strap_done <= 1'b1;
  end

  // buck c register; select resistor may replace the default code
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      buck_c_setting <= `BUCK_C_RESET;
    else if (wr_c)
      buck_c_setting <= wr_value;
    else if (!strap_done && default_select_resistor_sync)
      buck_c_setting[`CODE_MSB:0] <= BUCK_C_ALT_CODE_IN;
  end

  // applied buck b code only follows the register on commit
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      buck_b_applied <= vcode_t'(`BUCK_B_RESET);
    else if (go)
      buck_b_applied <= wr_b ? wr_value[`CODE_MSB:0] : buck_b_setting[`CODE_MSB:0];
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      commit_seen <= 1'b0;
    else
      commit_seen <= go;
  end

  blank_timer #(
    .CYCLES (BLANK_CYCLES)
  ) u_blank (
    .clk_in (CORE_CLK_IN),
    .rst_in (SYS_RST_IN),
    .bif    (bif.timer)
  );

  // converter controls; the code maps to volts in the analog loop
  assign BUCK_B_VOLTAGE_CODE_OUT           = buck_b_applied;
  assign BUCK_B_LIGHT_LOAD_SKIP_ENABLE_OUT = buck_b_setting[`SKIP_BIT];
  assign BUCK_C_VOLTAGE_CODE_OUT           = buck_c_setting[`CODE_MSB:0];
  assign BUCK_C_LIGHT_LOAD_SKIP_ENABLE_OUT = buck_c_setting[`SKIP_BIT];
  assign MONITOR_BLANK_OUT                 = bif.active;

  // bus steps: a request taken while idle, then the one-cycle answer
  sequence s_take;
    WB_CYC_IN && WB_STB_IN && bus_state == BUS_IDLE;
  endsequence

  sequence s_answer;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence

  // a protected write as the slave takes it, before the password gate
  sequence s_prot_write;
    WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_SEL_IN[0] && (hit_b || hit_c)
      && bus_state == BUS_IDLE;
  endsequence

  // the monitors stay blanked over the first cycles of the window
  sequence s_blank_run;
    MONITOR_BLANK_OUT [*4];
  endsequence

  // every taken request gets exactly one ack pulse
  chk_take_acked: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    s_take |=> s_answer)
    else $error("taken request not acked once");

  // a held ack would let the master retake the same request
  chk_ack_pulse: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held two cycles");

  // no ack without a request before it
  chk_ack_cause: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without request");

  // read data stands with the ack
  chk_rd_b: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (req && !WB_WE_IN && hit_b) |=> WB_DAT_OUT == {24'h00_0000, $past(buck_b_setting)})
    else $error("buck b read data wrong");

  // same for the second register
  chk_rd_c: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (req && !WB_WE_IN && hit_c) |=> WB_DAT_OUT == {24'h00_0000, $past(buck_c_setting)})
    else $error("buck c read data wrong");

  // unmapped words read as zero
  chk_rd_unmapped: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (req && !WB_WE_IN && !hit_b && !hit_c) |=> WB_DAT_OUT == 32'h0000_0000)
    else $error("unmapped read not zero");

  // read data only moves on a read
  chk_dat_hold: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !(req && !WB_WE_IN) |=> $stable(WB_DAT_OUT))
    else $error("read data moved without read");

  // reserved bit never stored
  chk_rsvd_zero: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !buck_b_setting[`RSVD_BIT] && !buck_c_setting[`RSVD_BIT])
    else $error("reserved bit set");

  // refused write leaves both registers alone
  chk_reject_keeps: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (s_prot_write and !PASSWORD_OK_IN) |=> $stable(buck_b_setting) && $stable(buck_c_setting))
    else $error("rejected write changed register");

  // refused write starts no blanking
  chk_reject_noblank: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (s_prot_write and !PASSWORD_OK_IN) |-> !bif.start)
    else $error("rejected write started blanking");

  // blanking only ever follows a passworded write
  chk_start_needs_pw: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    bif.start |-> PASSWORD_OK_IN && WB_WE_IN)
    else $error("blanking without password");

  // accepted write blanks the monitors
  chk_write_blanks: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (s_prot_write and PASSWORD_OK_IN) |=> s_blank_run)
    else $error("accepted write did not blank");

  // accepted buck b write lands
  chk_b_write: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_b |=> buck_b_setting == $past(wr_value))
    else $error("buck b write lost");

  // accepted buck c write lands, ahead of any strap load
  chk_c_write: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_c |=> buck_c_setting == $past(wr_value))
    else $error("buck c write lost");

  // buck b only changes on its own accepted write
  chk_b_hold: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !wr_b |=> $stable(buck_b_setting))
    else $error("buck b changed without write");

  // buck c only changes on its own write once the strap is done
  chk_c_hold: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (!wr_c && strap_done) |=> $stable(buck_c_setting))
    else $error("buck c changed without write");

  // a write with lane 0 off stores nothing
  chk_sel_ignored: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (req && WB_WE_IN && !WB_SEL_IN[0] && strap_done)
      |=> $stable(buck_b_setting) && $stable(buck_c_setting))
    else $error("unselected lane written");

  // applied buck b code holds until a commit
  chk_no_commit_hold: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !go |=> $stable(BUCK_B_VOLTAGE_CODE_OUT))
    else $error("buck b code moved without commit");

  // the cycle after a commit the code matches the register
  chk_commit_apply: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    commit_seen |-> BUCK_B_VOLTAGE_CODE_OUT == buck_b_setting[`CODE_MSB:0])
    else $error("commit did not apply code");

  // commit copies the stored code, not the bus data
  chk_commit_sets: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    go |=> BUCK_B_VOLTAGE_CODE_OUT == $past(buck_b_setting[`CODE_MSB:0]))
    else $error("commit applied wrong code");

  // mode bit of buck b follows the write at once
  chk_skip_follow: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_b |=> BUCK_B_LIGHT_LOAD_SKIP_ENABLE_OUT == $past(WB_DAT_IN[`SKIP_BIT]))
    else $error("skip bit not stored");

  // mode bit of buck c follows the write at once
  chk_skip_c_follow: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_c |=> BUCK_C_LIGHT_LOAD_SKIP_ENABLE_OUT == $past(WB_DAT_IN[`SKIP_BIT]))
    else $error("buck c skip bit not stored");

  // buck c code needs no commit
  chk_c_code_direct: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_c |=> BUCK_C_VOLTAGE_CODE_OUT == $past(WB_DAT_IN[`CODE_MSB:0]))
    else $error("buck c code not applied");

  // strap high right after reset loads the alternate code
  chk_strap_load: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (!strap_done && default_select_resistor_sync && !wr_c) |=> BUCK_C_VOLTAGE_CODE_OUT == $past(BUCK_C_ALT_CODE_IN))
    else $error("strap code not loaded");

  // the strap is caught once; later pin moves change nothing
  chk_strap_once: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (strap_done && !wr_c) |=> $stable(BUCK_C_VOLTAGE_CODE_OUT))
    else $error("strap reapplied");

  // reset values, looked at on the first edge after release
  chk_reset_b: assert property (
    @(posedge CORE_CLK_IN)
    $fell(SYS_RST_IN) |-> buck_b_setting == `BUCK_B_RESET)
    else $error("buck b reset value wrong");

  chk_reset_c_mode: assert property (
    @(posedge CORE_CLK_IN)
    $fell(SYS_RST_IN) |-> buck_c_setting[`SKIP_BIT:`RSVD_BIT] == 2'(`BUCK_C_RESET >> `RSVD_BIT))
    else $error("buck c reset value wrong");

  chk_reset_c_code: assert property (
    @(posedge CORE_CLK_IN)
    $fell(SYS_RST_IN) |-> BUCK_C_VOLTAGE_CODE_OUT == vcode_t'(`BUCK_C_RESET))
    else $error("buck c reset code wrong");

  chk_reset_skip: assert property (
    @(posedge CORE_CLK_IN)
    $fell(SYS_RST_IN) |-> BUCK_B_LIGHT_LOAD_SKIP_ENABLE_OUT && BUCK_C_LIGHT_LOAD_SKIP_ENABLE_OUT)
    else $error("skip bits not set by reset");

  chk_reset_applied: assert property (
    @(posedge CORE_CLK_IN)
    $fell(SYS_RST_IN) |-> BUCK_B_VOLTAGE_CODE_OUT == vcode_t'(`BUCK_B_RESET))
    else $error("buck b applied code reset wrong");

  // reset also clears any running blanking window
  chk_reset_noblank: assert property (
    @(posedge CORE_CLK_IN)
    $fell(SYS_RST_IN) |-> !MONITOR_BLANK_OUT)
    else $error("blanking survived reset");
endmodule

// ===== logic/buck_regs_defines.svh
/*
  constants for the buck converter setting registers: offsets, field
  positions, reset values and the monitor blanking time.
  assumes a 125 MHz core clock and a 32-bit classic wishbone slave port.
*/
`ifndef BUCK_REGS_DEFINES_SVH
`define BUCK_REGS_DEFINES_SVH

`define BUCK_B_INDEX        8'h17
`define BUCK_C_INDEX        8'h18
`define COMMIT_INDEX        8'h1a
`define BUCK_B_RESET        8'hb2
`define BUCK_C_RESET        8'hbd
`define SKIP_BIT            7
`define RSVD_BIT            6
`define CODE_MSB            5
`define COMMIT_BIT          0
`define ALT_COMMIT_BIT      1
`define CLK_FREQ_KHZ        125000
`define BLANK_TIME_MS       5
`define BLANK_CYCLES        (`BLANK_TIME_MS * `CLK_FREQ_KHZ)
`define BLANK_CNT_W         20

`endif

// ===== logic/buck_regs_pkg.sv
/*
  types shared by the buck setting register bank.
  assumes the defines header is compiled alongside.
*/
package buck_regs_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [5:0] vcode_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage

// ===== logic/blank_if.sv
/*
  interface between the register bank and its blanking timer.
  assumes one clock domain.
*/
`timescale 1ns/100ps
interface blank_if;
  logic start;
  logic active;
  modport ctrl  (output start, input active);
  modport timer (input start, output active);
endinterface

// ===== logic/blank_timer.sv
/*
  retriggerable monitor blanking timer; active while counting.
  assumes start is a one-cycle pulse from the same clock.
*/
`timescale 1ns/100ps
`include "buck_regs_defines.svh"
module blank_timer #(
  parameter int CYCLES = `BLANK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  blank_if.timer    bif
);
  localparam logic [`BLANK_CNT_W-1:0] LOAD = CYCLES[`BLANK_CNT_W-1:0];
  logic [`BLANK_CNT_W-1:0] count;

  initial begin
    if (CYCLES < 8 || CYCLES >= (1 << `BLANK_CNT_W))
      $error("blank_timer: CYCLES out of range");
  end

  // a fresh write restarts the full window
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      count <= '0;
    else if (bif.start)
      count <= LOAD;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign bif.active = (count != '0);

  chk_blank_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    bif.start |=> bif.active[*8]) else $error("blanking dropped early");
  chk_blank_ends: assert property (@(posedge clk_in) disable iff (rst_in)
    (count == 1 && !bif.start) |=> !bif.active) else $error("blanking overran");
endmodule

// ===== sim/tb.sv
/*
  self-checking bench for the buck setting register bank: classic wishbone
  reads and writes, password gating, commit, blanking and strap default.
  assumes the design's own assertions sit inside its files; no checker here.
*/
`timescale 1ns/100ps
module tb;
  import buck_regs_pkg::*;
  localparam int BLANK = 20;
  logic        clk, rst, cyc, stb, we, pw, default_select_resistor, ack, b_skip, c_skip, blank;
  logic [31:0] adr, dat_w, dat_r, rd;
  logic [3:0]  sel;
  vcode_t      alt, b_code, c_code;
  int          n_fail, checks_done;

  // short blanking count keeps the run brief
  buck_setting_regs #(.BLANK_CYCLES(BLANK)) i_buck_setting_regs (
    .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w),
    .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack), .PASSWORD_OK_IN(pw),
    .DEFAULT_SELECT_RESISTOR_IN(default_select_resistor), .BUCK_C_ALT_CODE_IN(alt),
    .BUCK_B_VOLTAGE_CODE_OUT(b_code), .BUCK_B_LIGHT_LOAD_SKIP_ENABLE_OUT(b_skip),
    .BUCK_C_VOLTAGE_CODE_OUT(c_code), .BUCK_C_LIGHT_LOAD_SKIP_ENABLE_OUT(c_skip),
    .MONITOR_BLANK_OUT(blank));

  // one comparison, counted
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single classic cycle; entered just after a rising edge
  task automatic wb_access(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat_w <= d;
    sel <= 4'h1;
    n = 0;
    // active region sees pre-edge values, so ack is read as sampled
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      $display("[FAIL] ack expected 1 seen %b", ack);
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk); // idle gap so the request is not retaken
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    wb_access(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // free-running core clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // main sequence
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 32'h0; dat_w = 32'h0;
    sel = 4'h0; pw = 1'b0; default_select_resistor = 1'b0; alt = 6'h2a; n_fail = 0; checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(32'h5c, 32'hb2, "buck_b_setting reset");
    rd_chk(32'h60, 32'hbd, "buck_c_setting reset");
    check("b code reset", 32'h32, {26'h0, b_code});
    check("b skip reset", 32'h1, {31'h0, b_skip});
    check("c code reset", 32'h3d, {26'h0, c_code});
    // password not done: write must vanish without blanking
    wb_access(1'b1, 32'h5c, 32'h05);
    rd_chk(32'h5c, 32'hb2, "b after refused write");
    check("blank after refused", 32'h0, {31'h0, blank});
    pw <= 1'b1;
    wb_access(1'b1, 32'h5c, 32'h45);
    check("blank after write", 32'h1, {31'h0, blank});
    rd_chk(32'h5c, 32'h05, "b with bit6 set");
    check("b code before commit", 32'h32, {26'h0, b_code});
    check("b skip cleared", 32'h0, {31'h0, b_skip});
    wb_access(1'b1, 32'h68, 32'h01);
    check("b code commit", 32'h05, {26'h0, b_code});
    wb_access(1'b1, 32'h5c, 32'hbf);
    wb_access(1'b1, 32'h68, 32'h02);
    check("b code alt commit", 32'h3f, {26'h0, b_code});
    check("b skip set", 32'h1, {31'h0, b_skip});
    wb_access(1'b1, 32'h60, 32'h41);
    rd_chk(32'h60, 32'h01, "c bit6 and skip");
    check("c code", 32'h01, {26'h0, c_code});
    check("c skip", 32'h0, {31'h0, c_skip});
    rd_chk(32'h40, 32'h0, "unmapped read");
    // retriggered blank still up, then gone once the count runs out
    repeat (BLANK - 10) @(posedge clk);
    check("blank held", 32'h1, {31'h0, blank});
    repeat (15) @(posedge clk);
    check("blank ended", 32'h0, {31'h0, blank});
    // strap high over a second reset selects the alternate code
    rst <= 1'b1;
    default_select_resistor <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    check("c strap code", 32'h2a, {26'h0, c_code});
    check("b code after reset", 32'h32, {26'h0, b_code});
    check("blank after reset", 32'h0, {31'h0, blank});
    rd_chk(32'h5c, 32'hb2, "b after second reset");
    give_verdict();
  end

  // watchdog well beyond the fewer than one hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule
